// *** cfg_bar_checker_assertions.sv ***
// Checker: port-level properties of the upper configuration header.
// Assumes it is bound to cfg_bar_regs and sees only its ports.
`timescale 1ns/100ps
module cfg_bar_checker (
    input wire logic        clk,
    input wire logic        reset_n,
    input wire logic        cfg_req,
    input wire logic        cfg_write,
    input wire logic [7:0]  cfg_addr,
    input wire logic        cfg_ack,
    input wire logic [31:0] cfg_rdata,
    input wire logic [15:0] command_reg,
    input wire logic        mem_req,
    input wire logic [31:0] mem_addr,
    input wire logic [31:0] local_rdata,
    input wire logic        devsel_n,
    input wire logic        mem_ack,
    input wire logic [31:0] mem_rdata,
    input wire logic        local_sel,
    input wire logic [19:0] local_offset,
    input wire logic        local_write
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // Config port answers
    cfg_ack_a: assert property (cfg_req && !cfg_ack |=> cfg_ack) else $error("no ack");
    ack_pulse_a: assert property (cfg_ack |=> !cfg_ack) else $error("long ack");
    base_low_a: assert property (cfg_ack && !$past(cfg_write) && $past(cfg_addr) == 8'h10
        |-> cfg_rdata[19:0] == 20'h0) else $error("base low bits");
    rsvd_zero_a: assert property (cfg_ack && !$past(cfg_write)
        && $past(cfg_addr) inside {[8'h14:8'h38]} |-> cfg_rdata == 32'h0)
        else $error("reserved nonzero");
    fixed_bytes_a: assert property (cfg_ack && !$past(cfg_write) && $past(cfg_addr) == 8'h3c
        |-> cfg_rdata[31:8] == 24'h0f0001) else $error("fixed bytes");
    // Memory claim
    claim_cause_a: assert property ($fell(devsel_n) |-> $past(mem_req) && $past(command_reg[1])
        && $past(mem_addr[31:20]) != 12'h0 && local_sel
        && local_offset == $past(mem_addr[19:0])) else $error("bad claim");
    no_enable_a: assert property (mem_req && devsel_n && !command_reg[1] |=> devsel_n)
        else $error("claim while disabled");
    claim_len_a: assert property ($fell(devsel_n) |->
        ##1 (!devsel_n && mem_ack) ##1 (devsel_n && !mem_ack)) else $error("claim length");
    read_data_a: assert property (mem_ack |->
        mem_rdata == ($past(local_write) ? 32'h0 : $past(local_rdata))) else $error("rdata");
    claim_c: cover property ($fell(devsel_n));
    cfg_wr_c: cover property (cfg_ack && $past(cfg_write));
    mem_wr_c: cover property (mem_ack && $past(local_write));
endmodule : cfg_bar_checker

bind cfg_bar_regs cfg_bar_checker u_chk (.clk(clk), .reset_n(reset_n), .cfg_req(cfg_req),
    .cfg_write(cfg_write), .cfg_addr(cfg_addr), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata),
    .command_reg(command_reg), .mem_req(mem_req), .mem_addr(mem_addr),
    .local_rdata(local_rdata), .devsel_n(devsel_n), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .local_sel(local_sel), .local_offset(local_offset),
    .local_write(local_write));

// *** cfg_bar_consts.svh ***
// Offsets, field positions, fixed values and reset values of the upper
// configuration header. Definitions only; included by the design files.
`ifndef CFG_BAR_CONSTS_SVH
`define CFG_BAR_CONSTS_SVH

`define OFS_BASE          8'h10
`define OFS_RSVD_FIRST    8'h14
`define OFS_RSVD_LAST     8'h38
`define OFS_LAT_GNT_INT   8'h3c
`define BASE_HI_MSB       31
`define BASE_HI_LSB       20
`define BASE_HI_WIDTH     12
`define BASE_RESET        12'h000
`define MAX_LAT_VALUE     8'h0f
`define MIN_GNT_VALUE     8'h00
`define INT_PIN_VALUE     8'h01
`define INT_LINE_RESET    8'h00
`define MEM_ENABLE_BIT    1

`endif

// *** cfg_bar_pkg.sv ***
// Types shared by the configuration header block.
// Assumes the consts header is included wherever numbers are needed.
package cfg_bar_pkg;

    typedef enum logic [1:0] {
        CYC_IDLE   = 2'b00,
        CYC_CLAIM  = 2'b01,
        CYC_ACCESS = 2'b10
    } cyc_state_type;

endpackage : cfg_bar_pkg

// *** cfg_bar_regs.sv ***
// Upper configuration header: memory base register, reserved dwords,
// latency/grant/interrupt dword, and memory window claim.
// Assumes a configuration port and a memory cycle port synchronous to clk;
// memory space enable comes from the command register elsewhere.
// Function
// - Claim memory cycle when address 31:20 matches nonzero base and space enabled.
// - Never claim while programmed base upper bits are all zero.
// - Unimplemented window locations read zero; writes complete with no effect.
// - Base bits 19:4 read zero, fixed 1 MB window only.
// - Base bit 3 reads zero, not prefetchable.
// - Base bits 2:1 read zero, anywhere in 32-bit space.
// - Base bit 0 reads zero, memory space base.
// - Base bits 31:20 writable, reset to zero.
// - Maximum latency byte at 3Ch reads constant 0Fh.
// - Minimum grant byte at 3Ch reads zero.
// - Interrupt pin byte at 3Ch reads 01h.
// - Interrupt line byte writable, resets zero, software writes routing.
// - Memory decode only while command bit 1 is set.
`timescale 1ns/100ps
`include "cfg_bar_consts.svh"

module cfg_bar_regs
    import cfg_bar_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset_n,
    // Configuration access port
    input  wire logic        cfg_req,
    input  wire logic        cfg_write,
    input  wire logic [7:0]  cfg_addr,
    input  wire logic [3:0]  cfg_byte_en,
    input  wire logic [31:0] cfg_wdata,
    output logic             cfg_ack,
    output logic [31:0]      cfg_rdata,
    // Memory cycle port
    input  wire logic [15:0] command_reg,
    input  wire logic        mem_req,
    input  wire logic        mem_write,
    input  wire logic [31:0] mem_addr,
    input  wire logic [31:0] local_rdata,
    output logic             devsel_n,
    output logic             mem_ack,
    output logic [31:0]      mem_rdata,
    output logic             local_sel,
    output logic [19:0]      local_offset,
    output logic             local_write
);

    // Assemble the base register read value
    function automatic logic [31:0] base_word(input logic [11:0] hi);
        base_word = {hi, 20'h00000};
    endfunction : base_word

    // Merge byte-enabled data into a byte
    function automatic logic [7:0] merge_byte(input logic [7:0] old_v,
                                              input logic [7:0] new_v,
                                              input logic       en);
        merge_byte = en ? new_v : old_v;
    endfunction : merge_byte

    // Dword offset of the memory base register
    function automatic logic is_base_offset(input logic [7:0] addr);
        is_base_offset = (addr == `OFS_BASE);
    endfunction : is_base_offset

    // Dword offset of the latency, grant and routing dword
    function automatic logic is_routing_offset(input logic [7:0] addr);
        is_routing_offset = (addr == `OFS_LAT_GNT_INT);
    endfunction : is_routing_offset

    // Reserved dwords; unaligned offsets there read zero as well
    function automatic logic is_reserved_offset(input logic [7:0] addr);
        is_reserved_offset = (addr >= `OFS_RSVD_FIRST) && (addr <= `OFS_RSVD_LAST);
    endfunction : is_reserved_offset

    // Read value of the routing dword: three fixed bytes and the line byte
    function automatic logic [31:0] routing_word(input logic [7:0] line);
        routing_word = {`MAX_LAT_VALUE, `MIN_GNT_VALUE, `INT_PIN_VALUE, line};
    endfunction : routing_word

    // Next stored base bits; lane 2 carries only bits 23:20
    function automatic logic [11:0] base_merge(input logic [11:0] old_v,
                                               input logic [31:0] data,
                                               input logic [3:0]  be);
        logic [11:0] v;
        v[11:4]    = merge_byte(old_v[11:4], data[31:24], be[3]);
        v[3:0]     = be[2] ? data[23:20] : old_v[3:0];
        base_merge = v;
    endfunction : base_merge

    // Data phase word: writes answer zero, reads pass the local word
    function automatic logic [31:0] local_word(input logic        was_write,
                                               input logic [31:0] word);
        local_word = was_write ? 32'h00000000 : word;
    endfunction : local_word

    // Offset inside the 1 MB window
    function automatic logic [19:0] window_offset(input logic [31:0] addr);
        window_offset = addr[19:0];
    endfunction : window_offset

    // Header storage
    logic [11:0]   base_hi_q;
    logic [11:0]   base_hi_d;
    logic [7:0]    int_line_q;
    logic [7:0]    int_line_d;

    // Configuration answer
    logic          cfg_take;
    logic          cfg_ack_q;
    logic          cfg_ack_d;
    logic [31:0]   cfg_rdata_q;
    logic [31:0]   cfg_rdata_d;

    // Claim sequencer
    logic          claim_now;
    cyc_state_type state_q;
    cyc_state_type state_d;
    logic          devsel_n_q;
    logic          devsel_n_d;
    logic          mem_ack_q;
    logic          mem_ack_d;

    // Local side and data phase
    logic [31:0]   mem_rdata_q;
    logic [31:0]   mem_rdata_d;
    logic          local_sel_q;
    logic          local_sel_d;
    logic [19:0]   local_offset_q;
    logic [19:0]   local_offset_d;
    logic          local_write_q;
    logic          local_write_d;
    logic          cycle_write_q;
    logic          cycle_write_d;
    logic          window_hit;

    window_decode u_decode (
        .mem_addr   (mem_addr),
        .base_hi    (base_hi_q),
        .mem_enable (command_reg[`MEM_ENABLE_BIT]),
        .hit        (window_hit)
    );

    // A request is taken when no acknowledge is standing
    assign cfg_take = cfg_req && !cfg_ack_q;

    // Writable bits of the header; everything else ignores writes
    always_comb begin
        base_hi_d  = base_hi_q;
        int_line_d = int_line_q;
        if (cfg_take && cfg_write) begin
            if (is_base_offset(cfg_addr)) begin
                // Only bits 31:20 are stored
                base_hi_d = base_merge(base_hi_q, cfg_wdata, cfg_byte_en);
            end else if (is_routing_offset(cfg_addr)) begin
                int_line_d = merge_byte(int_line_q, cfg_wdata[7:0],
                                        cfg_byte_en[0]);
            end else if (is_reserved_offset(cfg_addr)) begin
                // Reserved dwords hold no state
                int_line_d = int_line_q;
            end
        end
    end

    // Header storage registers
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            base_hi_q  <= `BASE_RESET;
            int_line_q <= `INT_LINE_RESET;
        end else begin
            base_hi_q  <= base_hi_d;
            int_line_q <= int_line_d;
        end
    end

    // Answer: one-cycle acknowledge, read data held until the next read
    always_comb begin
        cfg_ack_d   = cfg_take;
        cfg_rdata_d = cfg_rdata_q;
        if (cfg_take && !cfg_write) begin
            if (is_base_offset(cfg_addr)) begin
                cfg_rdata_d = base_word(base_hi_q);
            end else if (is_routing_offset(cfg_addr)) begin
                cfg_rdata_d = routing_word(int_line_q);
            end else if (is_reserved_offset(cfg_addr)) begin
                cfg_rdata_d = 32'h00000000;
            end else begin
                // Offsets outside this block read zero as well
                cfg_rdata_d = 32'h00000000;
            end
        end
    end

    // Answer registers
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            cfg_ack_q   <= 1'b0;
            cfg_rdata_q <= 32'h00000000;
        end else begin
            cfg_ack_q   <= cfg_ack_d;
            cfg_rdata_q <= cfg_rdata_d;
        end
    end

    // Claim starts in idle on a window hit with a request standing
    assign claim_now = (state_q == CYC_IDLE) && mem_req && window_hit;

    // Claim sequencer: devsel low for the claim and the data phase
    always_comb begin
        state_d    = state_q;
        devsel_n_d = devsel_n_q;
        mem_ack_d  = 1'b0;
        case (state_q)
            CYC_IDLE: begin
                devsel_n_d = 1'b1;
                if (claim_now) begin
                    state_d    = CYC_CLAIM;
                    devsel_n_d = 1'b0;
                end
            end
            CYC_CLAIM: begin
                // Data phase: acknowledge at the next edge
                state_d   = CYC_ACCESS;
                mem_ack_d = 1'b1;
            end
            CYC_ACCESS: begin
                // Turnaround: release the claim
                state_d    = CYC_IDLE;
                devsel_n_d = 1'b1;
            end
            default: begin
                state_d    = CYC_IDLE;
                devsel_n_d = 1'b1;
            end
        endcase
    end

    // Sequencer registers
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_q    <= CYC_IDLE;
            devsel_n_q <= 1'b1;
            mem_ack_q  <= 1'b0;
        end else begin
            state_q    <= state_d;
            devsel_n_q <= devsel_n_d;
            mem_ack_q  <= mem_ack_d;
        end
    end

    // Local side: strobe and offset at claim, data captured for the ack
    always_comb begin
        local_sel_d    = claim_now;
        local_offset_d = local_offset_q;
        local_write_d  = 1'b0;
        cycle_write_d  = cycle_write_q;
        mem_rdata_d    = mem_rdata_q;
        if (claim_now) begin
            // Capture address and direction at the claim edge
            local_offset_d = window_offset(mem_addr);
            local_write_d  = mem_write;
            cycle_write_d  = mem_write;
        end
        if (state_q == CYC_CLAIM) begin
            // Unbacked locations come back zero from the local side
            mem_rdata_d = local_word(cycle_write_q, local_rdata);
        end
    end

    // Local side registers
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            mem_rdata_q    <= 32'h00000000;
            local_sel_q    <= 1'b0;
            local_offset_q <= 20'h00000;
            local_write_q  <= 1'b0;
            cycle_write_q  <= 1'b0;
        end else begin
            mem_rdata_q    <= mem_rdata_d;
            local_sel_q    <= local_sel_d;
            local_offset_q <= local_offset_d;
            local_write_q  <= local_write_d;
            cycle_write_q  <= cycle_write_d;
        end
    end

    // Configuration port outputs, straight from flip-flops
    assign cfg_ack      = cfg_ack_q;
    assign cfg_rdata    = cfg_rdata_q;

    // Claim and data phase outputs
    assign devsel_n     = devsel_n_q;
    assign mem_ack      = mem_ack_q;
    assign mem_rdata    = mem_rdata_q;

    // Local side outputs
    assign local_sel    = local_sel_q;
    assign local_offset = local_offset_q;
    assign local_write  = local_write_q;

endmodule : cfg_bar_regs

// *** func_internals.sv ***
// Model of the function internals behind the memory window.
// Assumes the offset is held from claim; one word is implemented.
`timescale 1ns/100ps
module func_internals #(parameter logic [31:0] WORD = 32'h1234_5678) (
    input wire logic [19:0] local_offset,
    output logic     [31:0] local_rdata
);
    // Word at offset zero, zero for every unimplemented place
    assign local_rdata = (local_offset == 20'h0) ? WORD : 32'h0;
endmodule : func_internals

// *** tb.sv ***
// Testbench: config and memory cycle sequences with expected values.
// Assumes cfg_bar_regs, its checker and func_internals are compiled first.
`timescale 1ns/100ps
module tb;
    localparam logic [31:0] WORD = 32'h1234_5678;
    logic clk = 1'b0, reset_n = 1'b0, cfg_req = 1'b0, cfg_write = 1'b0;
    logic mem_req = 1'b0, mem_write = 1'b0, cfg_ack, devsel_n, mem_ack, local_sel, local_write;
    logic [7:0] cfg_addr = 8'h0;
    logic [3:0] cfg_byte_en = 4'h0;
    logic [15:0] command_reg = 16'h0;
    logic [31:0] cfg_wdata = 32'h0, mem_addr = 32'h0, cfg_rdata, mem_rdata, local_rdata;
    logic [19:0] local_offset;
    int miscompares = 0, compares = 0;

    cfg_bar_regs DUT (.clk(clk), .reset_n(reset_n), .cfg_req(cfg_req), .cfg_write(cfg_write),
        .cfg_addr(cfg_addr), .cfg_byte_en(cfg_byte_en), .cfg_wdata(cfg_wdata),
        .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata), .command_reg(command_reg),
        .mem_req(mem_req), .mem_write(mem_write), .mem_addr(mem_addr),
        .local_rdata(local_rdata), .devsel_n(devsel_n), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata), .local_sel(local_sel), .local_offset(local_offset),
        .local_write(local_write));
    func_internals #(.WORD(WORD)) u_fn (.local_offset(local_offset), .local_rdata(local_rdata));

    // Clock and watchdog
    always #25 clk = ~clk;
    initial begin
        repeat (3000) @(posedge clk);
        miscompares++;
        summarize();
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Config access held until acknowledged
    task automatic cfg(input logic wr, input logic [7:0] a, input logic [3:0] be,
                       input logic [31:0] d, output logic [31:0] q);
        @(negedge clk);
        cfg_req = 1'b1;
        cfg_write = wr;
        cfg_addr = a;
        cfg_byte_en = be;
        cfg_wdata = d;
        @(negedge clk);
        while (cfg_ack !== 1'b1) @(negedge clk);
        q = cfg_rdata;
        cfg_req = 1'b0;
    endtask : cfg

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        cfg(1'b0, a, 4'h0, 32'h0, q);
        chk(q, exp);
    endtask : rd

    task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        logic [31:0] q;
        cfg(1'b1, a, be, d, q);
    endtask : wr

    // One memory cycle, claim, strobes and data checked at fixed offsets
    task automatic mem(input logic w, input logic [31:0] a, input logic hit,
                       input logic [31:0] exp);
        @(negedge clk);
        mem_req = 1'b1;
        mem_write = w;
        mem_addr = a;
        @(negedge clk);
        mem_req = 1'b0;
        chk({31'h0, devsel_n}, {31'h0, !hit});
        chk({31'h0, local_sel}, {31'h0, hit});
        chk({31'h0, local_write}, {31'h0, hit && w});
        if (hit) chk({12'h0, local_offset}, {12'h0, a[19:0]});
        @(negedge clk);
        chk({31'h0, mem_ack}, {31'h0, hit});
        chk({31'h0, devsel_n}, {31'h0, !hit});
        chk({31'h0, local_sel}, 32'h0);
        if (hit) chk(mem_rdata, exp);
        @(negedge clk);
        chk({30'h0, devsel_n, mem_ack}, 32'h2);
        @(negedge clk);
    endtask : mem

    task automatic summarize;
        if (miscompares == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : summarize

    initial begin
        repeat (8) @(negedge clk);
        reset_n = 1'b1;
        rd(8'h10, 32'h0);
        rd(8'h3c, 32'h0f00_0100);
        wr(8'h10, 4'hf, 32'hffff_ffff);
        rd(8'h10, 32'hfff0_0000);
        wr(8'h10, 4'hb, 32'h0);
        rd(8'h10, 32'h00f0_0000);
        for (int a = 8'h14; a <= 8'h38; a += 4) begin
            wr(a[7:0], 4'hf, 32'hffff_ffff);
            rd(a[7:0], 32'h0);
        end
        rd(8'hc0, 32'h0);
        wr(8'h3c, 4'hf, 32'hffff_ffff);
        wr(8'h3c, 4'he, 32'h0);
        rd(8'h3c, 32'h0f00_01ff);
        command_reg = 16'h0002;
        mem(1'b0, 32'h00f0_0000, 1'b1, WORD);
        mem(1'b0, 32'h00f1_2340, 1'b1, 32'h0);
        mem(1'b1, 32'h00fa_bcd0, 1'b1, 32'h0);
        mem(1'b0, 32'h0100_0000, 1'b0, 32'h0);
        command_reg = 16'hfffd;
        mem(1'b0, 32'h00f0_0000, 1'b0, 32'h0);
        command_reg = 16'h0002;
        wr(8'h10, 4'hf, 32'h0);
        mem(1'b0, 32'h0000_0000, 1'b0, 32'h0);
        // Mid-run reset clears the interrupt line byte
        @(negedge clk);
        reset_n = 1'b0;
        repeat (2) @(negedge clk);
        reset_n = 1'b1;
        rd(8'h3c, 32'h0f00_0100);
        rd(8'h10, 32'h0);
        summarize();
    end
endmodule : tb

// *** window_decode.sv ***
// Memory window decoder for the 1 MB window.
// Assumes address and enables are synchronous to clk; purely combinational.
`timescale 1ns/100ps
`include "cfg_bar_consts.svh"

module window_decode (
    input  wire logic [31:0] mem_addr,
    input  wire logic [11:0] base_hi,
    input  wire logic        mem_enable,
    output logic             hit
);

    // Match upper bits, nonzero base, space enabled
    always_comb begin
        hit = (mem_addr[`BASE_HI_MSB:`BASE_HI_LSB] == base_hi)
              && (base_hi != `BASE_RESET)
              && mem_enable;
    end

endmodule : window_decode
